// ===== sgsl_pkg.sv
// Package with constants and carrier types for the safety gate switch logic
package sgsl_pkg;

    // ==========================================================
    // Timebase
    // ==========================================================
    localparam int unsigned CLK_FREQ_HZ    = 250_000_000;
    localparam int unsigned TICK_TIME_US   = 1000;
    localparam int unsigned TICK_CYCLES    = (CLK_FREQ_HZ / 1_000_000) * TICK_TIME_US;
    localparam int unsigned LOCK_TIMEOUT_MS = 600;
    localparam int unsigned MIN_LOW_MS      = 500;
    localparam int unsigned RETEST_COUNT    = 7;
    localparam int unsigned MS_CNT_W        = 10;
    localparam int unsigned TRY_CNT_W       = 3;

    // ==========================================================
    // Guard lock states
    // ==========================================================
    typedef enum logic [4:0] {
        SGSL_LK_IDLE  = 5'h01,
        SGSL_LK_TEST  = 5'h02,
        SGSL_LK_HELD  = 5'h04,
        SGSL_LK_FAIL  = 5'h08,
        SGSL_LK_REARM = 5'h10
    } sgsl_lock_state_t;

    // Synchronised external inputs travel together
    typedef struct packed {
        logic safety_in_ch1;
        logic safety_in_ch2;
        logic lock_command_in;
        logic actuator_present;
        logic holding_force_ok;
    } sgsl_inputs_t;

    // Status bundle
    typedef struct packed {
        logic unequal_input;
        logic plausibility_error;
        logic partial_lock;
        logic locking_error;
    } sgsl_status_t;

    localparam int unsigned IN_W = $bits(sgsl_inputs_t);

endpackage : sgsl_pkg

// ===== sgsl_sync.sv
// Two-stage input synchroniser, parameterised in width
`timescale 1ns/10ps
module sgsl_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    // ==========================================================
    // Synchroniser flops
    // ==========================================================
    // First stage feeds only the second stage
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            meta_q <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : sgsl_sync

// ===== sgsl_top.sv
// Safety gate switch logic: safety outputs, plausibility and guard lock control
`timescale 1ns/10ps
module sgsl_top (
    input  wire logic I_REF_CLK,
    input  wire logic I_RESET,
    input  wire logic I_SAFETY_IN_CH1,
    input  wire logic I_SAFETY_IN_CH2,
    input  wire logic I_LOCK_COMMAND_IN,
    input  wire logic I_ACTUATOR_PRESENT,
    input  wire logic I_HOLDING_FORCE_OK,
    output logic      O_SWITCHING_SAFETY_OUTPUT_CH1,
    output logic      O_SWITCHING_SAFETY_OUTPUT_CH2,
    output logic      O_LOCK_STATUS_OUT,
    output logic      O_MAGNET_ON,
    output logic      O_UNEQUAL_INPUT,
    output logic      O_PLAUSIBILITY_ERROR,
    output logic      O_PARTIAL_LOCK,
    output logic      O_LOCKING_ERROR
);

    // ==========================================================
    // Declarations
    // ==========================================================
    sgsl_pkg::sgsl_inputs_t     raw_in;
    sgsl_pkg::sgsl_inputs_t     in_s;
    logic [sgsl_pkg::IN_W-1:0]  in_bits;
    logic                       ch1_q;
    logic                       ch2_q;
    logic                       cmd_q;
    logic [17:0]                tick_cnt_q;
    logic                       tick;
    logic                       unequal_q;
    logic                       unequal_ch1_q;
    logic                       perr_q;
    logic                       partial_q;
    logic                       switching_safety_output_q;
    sgsl_pkg::sgsl_lock_state_t lk_state_q;
    sgsl_pkg::sgsl_lock_state_t lk_state_d;
    logic [sgsl_pkg::MS_CNT_W-1:0]  ms_cnt_q;
    logic [sgsl_pkg::TRY_CNT_W-1:0] try_cnt_q;
    logic                       powerup_q;
    logic                       status_q;
    logic                       lock_err_q;
    logic                       low_ok_q;
    logic                       timeout;
    logic                       ch1_fall_alone;
    logic                       ch2_fall_alone;

    localparam logic [17:0] TICK_LAST = 18'(sgsl_pkg::TICK_CYCLES - 1);
    localparam logic [sgsl_pkg::MS_CNT_W-1:0] LOCK_MS =
        sgsl_pkg::MS_CNT_W'(sgsl_pkg::LOCK_TIMEOUT_MS);
    localparam logic [sgsl_pkg::MS_CNT_W-1:0] LOW_MS =
        sgsl_pkg::MS_CNT_W'(sgsl_pkg::MIN_LOW_MS);
    localparam logic [sgsl_pkg::TRY_CNT_W-1:0] TRY_LAST =
        sgsl_pkg::TRY_CNT_W'(sgsl_pkg::RETEST_COUNT);

    // ==========================================================
    // Input synchronisation
    // ==========================================================
    // All pins pass two flops before any logic sees them
    assign raw_in.safety_in_ch1    = I_SAFETY_IN_CH1;
    assign raw_in.safety_in_ch2    = I_SAFETY_IN_CH2;
    assign raw_in.lock_command_in  = I_LOCK_COMMAND_IN;
    assign raw_in.actuator_present = I_ACTUATOR_PRESENT;
    assign raw_in.holding_force_ok = I_HOLDING_FORCE_OK;

    sgsl_sync #(
        .WIDTH   (sgsl_pkg::IN_W)
    ) u_sync (
        .i_clk   (I_REF_CLK),
        .i_reset (I_RESET),
        .i_async (raw_in),
        .o_sync  (in_bits)
    );
    assign in_s = sgsl_pkg::sgsl_inputs_t'(in_bits);

    // ==========================================================
    // Millisecond tick
    // ==========================================================
    // Free running; timings are thus accurate to one tick
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            tick_cnt_q <= 18'h0;
        else if (tick_cnt_q == TICK_LAST)
            tick_cnt_q <= 18'h0;
        else
            tick_cnt_q <= tick_cnt_q + 18'h1;
    end
    assign tick = (tick_cnt_q == TICK_LAST);

    // Previous input levels for edge detection
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            ch1_q <= 1'b0;
            ch2_q <= 1'b0;
            cmd_q <= 1'b0;
        end
        else
        begin
            ch1_q <= in_s.safety_in_ch1;
            ch2_q <= in_s.safety_in_ch2;
            cmd_q <= in_s.lock_command_in;
        end
    end

    // ==========================================================
    // Plausibility monitoring
    // ==========================================================
    assign ch1_fall_alone = ch1_q && !in_s.safety_in_ch1 && in_s.safety_in_ch2;
    assign ch2_fall_alone = ch2_q && !in_s.safety_in_ch2 && in_s.safety_in_ch1;

    // Unequal flag remembers which channel dropped alone
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            unequal_q     <= 1'b0;
            unequal_ch1_q <= 1'b0;
        end
        else if (ch1_fall_alone || ch2_fall_alone)
        begin
            unequal_q     <= 1'b1;
            unequal_ch1_q <= ch1_fall_alone;
        end
        else if (!in_s.safety_in_ch1 && !in_s.safety_in_ch2)
            unequal_q <= 1'b0;
        else if (unequal_q && in_s.safety_in_ch1 && in_s.safety_in_ch2)
            unequal_q <= 1'b0;
    end

    // Rise of the dropped channel while other high locks
    // Only a joint low clears it; set has priority
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            perr_q    <= 1'b0;
            partial_q <= 1'b0;
        end
        else if (unequal_q && in_s.safety_in_ch1 && in_s.safety_in_ch2)
        begin
            perr_q    <= 1'b1;
            partial_q <= 1'b1;
        end
        else if (!in_s.safety_in_ch1 && !in_s.safety_in_ch2)
        begin
            perr_q    <= 1'b0;
            partial_q <= 1'b0;
        end
    end

    // ==========================================================
    // Safety outputs
    // ==========================================================
    // Independent of lock state; forced opening drops them
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            switching_safety_output_q <= 1'b0;
        else
            switching_safety_output_q <= in_s.actuator_present && in_s.safety_in_ch1 &&
                      in_s.safety_in_ch2 && !partial_q &&
                      !(unequal_q && in_s.safety_in_ch1 && in_s.safety_in_ch2);
    end

    // ==========================================================
    // Guard lock sequencing
    // ==========================================================
    assign timeout = tick && (ms_cnt_q >= LOCK_MS - 1'b1);

    // Next state
    always_comb
    begin
        lk_state_d = lk_state_q;
        case (lk_state_q)
            sgsl_pkg::SGSL_LK_IDLE:
                if (in_s.actuator_present && in_s.lock_command_in)
                    lk_state_d = sgsl_pkg::SGSL_LK_TEST;
            sgsl_pkg::SGSL_LK_TEST:
                if (!in_s.actuator_present || !in_s.lock_command_in)
                    lk_state_d = sgsl_pkg::SGSL_LK_IDLE;
                else if (in_s.holding_force_ok)
                    lk_state_d = sgsl_pkg::SGSL_LK_HELD;
                else if (timeout && (!powerup_q || try_cnt_q == TRY_LAST))
                    lk_state_d = sgsl_pkg::SGSL_LK_FAIL;
            sgsl_pkg::SGSL_LK_HELD:
                if (!in_s.actuator_present || !in_s.lock_command_in)
                    lk_state_d = sgsl_pkg::SGSL_LK_IDLE;
            sgsl_pkg::SGSL_LK_FAIL:
                if (!in_s.lock_command_in)
                    lk_state_d = sgsl_pkg::SGSL_LK_REARM;
            sgsl_pkg::SGSL_LK_REARM:
                if (in_s.lock_command_in)
                    lk_state_d = low_ok_q ? sgsl_pkg::SGSL_LK_IDLE
                                          : sgsl_pkg::SGSL_LK_FAIL;
            default:
                lk_state_d = sgsl_pkg::SGSL_LK_IDLE;
        endcase
    end

    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            lk_state_q <= sgsl_pkg::SGSL_LK_IDLE;
        else
            lk_state_q <= lk_state_d;
    end

    // Millisecond timer for lock timeout and command low time
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            ms_cnt_q <= '0;
        else if (lk_state_d != lk_state_q)
            ms_cnt_q <= '0;
        else if (lk_state_q == sgsl_pkg::SGSL_LK_TEST && timeout)
            ms_cnt_q <= '0;                         // Restart for next retest
        else if (tick && ms_cnt_q != {sgsl_pkg::MS_CNT_W{1'b1}})
            ms_cnt_q <= ms_cnt_q + 1'b1;
    end

    // Command low time qualification
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            low_ok_q <= 1'b0;
        else if (lk_state_q != sgsl_pkg::SGSL_LK_REARM)
            low_ok_q <= 1'b0;
        else if (tick && ms_cnt_q >= LOW_MS - 1'b1)
            low_ok_q <= 1'b1;
    end

    // Power-up retest bookkeeping; first lock attempt after reset
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            powerup_q <= 1'b1;
            try_cnt_q <= '0;
        end
        else if (lk_state_q == sgsl_pkg::SGSL_LK_TEST)
        begin
            if (in_s.holding_force_ok || lk_state_d == sgsl_pkg::SGSL_LK_FAIL)
                powerup_q <= 1'b0;
            else if (timeout && powerup_q)
                try_cnt_q <= try_cnt_q + 1'b1;
        end
    end

    // ==========================================================
    // Lock status output and error flag
    // ==========================================================
    // Follows presence; drops on lock failure until rearmed
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            status_q <= 1'b0;
        else
            status_q <= in_s.actuator_present &&
                        lk_state_d != sgsl_pkg::SGSL_LK_FAIL &&
                        lk_state_d != sgsl_pkg::SGSL_LK_REARM;
    end

    // Locking error shown while magnet failed
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            lock_err_q <= 1'b0;
        else
            lock_err_q <= (lk_state_d == sgsl_pkg::SGSL_LK_FAIL) ||
                          (lk_state_d == sgsl_pkg::SGSL_LK_REARM);
    end

    // Magnet is combinational so it drops the same cycle as presence
    assign O_MAGNET_ON = in_s.lock_command_in && in_s.actuator_present &&
                         (lk_state_q == sgsl_pkg::SGSL_LK_TEST ||
                          lk_state_q == sgsl_pkg::SGSL_LK_HELD);

    assign O_SWITCHING_SAFETY_OUTPUT_CH1 = switching_safety_output_q;
    assign O_SWITCHING_SAFETY_OUTPUT_CH2 = switching_safety_output_q;
    assign O_LOCK_STATUS_OUT             = status_q;
    assign O_UNEQUAL_INPUT               = unequal_q;
    assign O_PLAUSIBILITY_ERROR          = perr_q;
    assign O_PARTIAL_LOCK                = partial_q;
    assign O_LOCKING_ERROR               = lock_err_q;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);

    switching_safety_output_needs_all_a: assert property (switching_safety_output_q |-> $past(in_s.actuator_present)
        && $past(in_s.safety_in_ch1) && $past(in_s.safety_in_ch2))
        else $error("Safety output high without its conditions");
    switching_safety_output_drop_a: assert property (!in_s.actuator_present |=> !switching_safety_output_q)
        else $error("Safety output stays high with actuator absent");
    switching_safety_output_lock_indep_a: assert property ((in_s.actuator_present && in_s.safety_in_ch1
        && in_s.safety_in_ch2 && !partial_q && !unequal_q) |=> switching_safety_output_q)
        else $error("Safety output blocked by lock state");
    status_absent_a: assert property (!in_s.actuator_present |=> !status_q)
        else $error("Lock status high with actuator absent");
    unequal_set_a: assert property (ch1_fall_alone |=> unequal_q && unequal_ch1_q)
        else $error("Unequal status not flagged");
    plaus_lock_a: assert property ((unequal_q && in_s.safety_in_ch1
        && in_s.safety_in_ch2) |=> partial_q ##1 !switching_safety_output_q)
        else $error("Partial lock not entered");
    partial_clear_a: assert property ($fell(partial_q) |->
        $past(!in_s.safety_in_ch1 && !in_s.safety_in_ch2))
        else $error("Partial lock left without joint low");
    magnet_gate_a: assert property (O_MAGNET_ON |-> in_s.lock_command_in
        && in_s.actuator_present)
        else $error("Magnet energised without command and presence");
    fail_status_a: assert property ((lk_state_q == sgsl_pkg::SGSL_LK_FAIL) |=>
        !status_q && lock_err_q)
        else $error("Lock failure not reflected on status");
    rearm_a: assert property ((lk_state_q == sgsl_pkg::SGSL_LK_REARM
        && lk_state_d == sgsl_pkg::SGSL_LK_IDLE) |-> low_ok_q)
        else $error("Rearmed before minimum low time");

    lock_ok_c: cover property (lk_state_q == sgsl_pkg::SGSL_LK_HELD);
    lock_fail_c: cover property (lk_state_q == sgsl_pkg::SGSL_LK_FAIL);
    partial_c: cover property ($rose(partial_q));
    switching_safety_output_on_c: cover property ($rose(switching_safety_output_q));

endmodule : sgsl_top

// ===== sgsl_far_end.sv
// Far-end model: upstream safety switch, lock controller and magnet feedback
`timescale 1ns/10ps
module sgsl_far_end #(
    parameter int unsigned MIN_LOW_CYC = 125_000_000,
    parameter int unsigned FAST_FORCE  = 3,
    parameter int unsigned SLOW_FORCE  = 200
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_ch1_req,
    input  wire logic i_ch2_req,
    input  wire logic i_lock_req,
    input  wire logic i_gate_req,
    input  wire logic i_slow,
    input  wire logic i_magnet_on,
    output logic      o_ch1,
    output logic      o_ch2,
    output logic      o_lock_cmd,
    output logic      o_actuator,
    output logic      o_force_ok
);
    int unsigned low_cnt_q;
    logic        was_high_q;
    int unsigned mag_cnt_q;

    // ==========================================================
    // Upstream chain and gate position
    // ==========================================================
    // Upstream switch levels, one cycle behind the request
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_ch1      <= 1'b0;
            o_ch2      <= 1'b0;
            o_actuator <= 1'b0;
        end
        else
        begin
            o_ch1      <= i_ch1_req;
            o_ch2      <= i_ch2_req;
            o_actuator <= i_gate_req;
        end
    end

    // ==========================================================
    // Lock controller
    // ==========================================================
    // A re-raise is held back until the low time has run out
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_lock_cmd <= 1'b0;
            low_cnt_q  <= 0;
            was_high_q <= 1'b0;
        end
        else if (o_lock_cmd)
        begin
            o_lock_cmd <= i_lock_req;
            low_cnt_q  <= 0;
        end
        else
        begin
            if (low_cnt_q < MIN_LOW_CYC)
                low_cnt_q <= low_cnt_q + 1;
            if (i_lock_req && (!was_high_q || low_cnt_q >= MIN_LOW_CYC))
            begin
                o_lock_cmd <= 1'b1;
                was_high_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Magnet feedback
    // ==========================================================
    // Force builds up only while the magnet stays energised; slow mode mimics a dirty plate
    // Reset branch kept pure so the magnet level is only sampled on the clock
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            mag_cnt_q  <= 0;
            o_force_ok <= 1'b0;
        end
        else if (!i_magnet_on)
        begin
            mag_cnt_q  <= 0;
            o_force_ok <= 1'b0;
        end
        else
        begin
            if (mag_cnt_q < SLOW_FORCE)
                mag_cnt_q <= mag_cnt_q + 1;
            o_force_ok <= (mag_cnt_q >= (i_slow ? SLOW_FORCE : FAST_FORCE));
        end
    end
endmodule : sgsl_far_end

// ===== sgsl_top_test.sv
// Self-checking testbench for the safety gate switch logic
`timescale 1ns/10ps
module sgsl_top_test;
    localparam int SETTLE = 6;

    logic clk      = 1'b0;
    logic rst      = 1'b1;
    logic ch1_req  = 1'b0;
    logic ch2_req  = 1'b0;
    logic lock_req = 1'b0;
    logic gate_req = 1'b0;
    logic slow     = 1'b0;
    logic ch1, ch2, lock_cmd, actuator, force_ok;
    logic ossd1, ossd2, status, magnet, uneq, perr, partial, lock_err;
    int   num_errors = 0;
    int   tests_run  = 0;

    // ==========================================================
    // Clock, partner and device
    // ==========================================================
    always #2 clk = ~clk;

    sgsl_far_end far_u (
        .i_clk(clk), .i_reset(rst), .i_ch1_req(ch1_req), .i_ch2_req(ch2_req),
        .i_lock_req(lock_req), .i_gate_req(gate_req), .i_slow(slow),
        .i_magnet_on(magnet), .o_ch1(ch1), .o_ch2(ch2), .o_lock_cmd(lock_cmd),
        .o_actuator(actuator), .o_force_ok(force_ok)
    );

    sgsl_top dut_u (
        .I_REF_CLK(clk), .I_RESET(rst), .I_SAFETY_IN_CH1(ch1), .I_SAFETY_IN_CH2(ch2),
        .I_LOCK_COMMAND_IN(lock_cmd), .I_ACTUATOR_PRESENT(actuator),
        .I_HOLDING_FORCE_OK(force_ok), .O_SWITCHING_SAFETY_OUTPUT_CH1(ossd1),
        .O_SWITCHING_SAFETY_OUTPUT_CH2(ossd2), .O_LOCK_STATUS_OUT(status),
        .O_MAGNET_ON(magnet), .O_UNEQUAL_INPUT(uneq), .O_PLAUSIBILITY_ERROR(perr),
        .O_PARTIAL_LOCK(partial), .O_LOCKING_ERROR(lock_err)
    );

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic check(input string what, input logic exp, input logic seen);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask : check

    // Both channels always judged together
    task automatic check_switching_safety_output(input logic exp);
        check("ossd1", exp, ossd1);
        check("ossd2", exp, ossd2);
    endtask : check_switching_safety_output

    // Model adds one cycle, the synchroniser two more; settle past both
    task automatic apply(input logic c1, input logic c2, input logic lk, input logic gt);
        @(posedge clk);
        ch1_req  <= c1;
        ch2_req  <= c2;
        lock_req <= lk;
        gate_req <= gt;
        repeat (SETTLE) @(posedge clk);
        #1;
    endtask : apply

    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Outputs quiet while reset is held
    task automatic t_reset();
        #1;
        check_switching_safety_output(1'b0);
        check("status", 1'b0, status);
        check("magnet", 1'b0, magnet);
    endtask : t_reset

    // Gate and chain gating of the safety outputs, lock released
    task automatic t_pass();
        apply(1'b1, 1'b1, 1'b0, 1'b1);
        check_switching_safety_output(1'b1);
        check("status", 1'b1, status);
        check("magnet", 1'b0, magnet);
        apply(1'b1, 1'b1, 1'b0, 1'b0);
        check_switching_safety_output(1'b0);
        check("status", 1'b0, status);
        apply(1'b0, 1'b0, 1'b0, 1'b1);
        check_switching_safety_output(1'b0);
        check("status", 1'b1, status);
    endtask : t_pass

    // Slow force within timeout, forced opening, then unlock
    task automatic t_lock();
        slow <= 1'b1;
        apply(1'b1, 1'b1, 1'b1, 1'b1);
        check("magnet", 1'b1, magnet);
        check_switching_safety_output(1'b1);
        repeat (300) @(posedge clk);
        #1;
        check("status", 1'b1, status);
        check("lock_err", 1'b0, lock_err);
        check_switching_safety_output(1'b1);
        slow <= 1'b0;
        apply(1'b1, 1'b1, 1'b1, 1'b0);
        check_switching_safety_output(1'b0);
        check("status", 1'b0, status);
        check("magnet", 1'b0, magnet);
        apply(1'b1, 1'b1, 1'b1, 1'b1);
        check("magnet", 1'b1, magnet);
        check("status", 1'b1, status);
        check_switching_safety_output(1'b1);
        apply(1'b1, 1'b1, 1'b0, 1'b1);
        check("magnet", 1'b0, magnet);
        check("status", 1'b1, status);
    endtask : t_lock

    // One channel drops and returns alone, on each channel in turn
    task automatic t_plaus();
        for (int c = 0; c < 2; c++)
        begin
            apply(c[0], !c[0], 1'b0, 1'b1);
            check("unequal", 1'b1, uneq);
            check_switching_safety_output(1'b0);
            apply(1'b1, 1'b1, 1'b0, 1'b1);
            check("perr", 1'b1, perr);
            check("partial", 1'b1, partial);
            check_switching_safety_output(1'b0);
            apply(1'b0, 1'b0, 1'b0, 1'b1);
            check("partial", 1'b0, partial);
            apply(1'b1, 1'b1, 1'b0, 1'b1);
            check("partial", 1'b0, partial);
            check_switching_safety_output(1'b1);
        end
    endtask : t_plaus

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial
    begin
        t_reset();
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_pass();
        t_lock();
        t_plaus();
        end_of_test();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule : sgsl_top_test
